// ### hdl/bam_pkg.sv
/*
 * bam_pkg: shared constants for the break and monitor-entry block.
 * Assumes a 50 MHz system clock and an 8-bit register port.
 */
package bam_pkg;
    // register offsets
    localparam logic [2:0] ADDR_BRK_STATUS_CONTROL = 3'h0;
    localparam logic [2:0] ADDR_BRK_ADDRESS_HIGH = 3'h1;
    localparam logic [2:0] ADDR_BRK_ADDRESS_LOW = 3'h2;
    localparam logic [2:0] ADDR_BRK_AUXILIARY = 3'h3;
    localparam logic [2:0] ADDR_BRK_STATUS = 3'h4;
    localparam logic [2:0] ADDR_BRK_FLAG_CONTROL = 3'h5;
    localparam logic [2:0] ADDR_MON_STATUS = 3'h6;
    // field positions
    localparam int BIT_BREAK_ENABLE = 7;
    localparam int BIT_BREAK_ACTIVE = 6;
    localparam int BIT_WATCHDOG_DISABLE = 0;
    localparam int BIT_WAIT_EXIT = 1;
    localparam int BIT_CLEAR_FLAG_ENABLE = 7;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    // vectors
    localparam logic [15:0] VEC_BREAK_USER = 16'hFFFC;
    localparam logic [15:0] VEC_BREAK_MON = 16'hFEFC;
    localparam logic [15:0] TRIM_ADDRESS = 16'hFFC0;
    localparam logic [7:0] SWI_OPCODE = 8'h83;
    // link bit period in bus clocks
    localparam logic [8:0] BIT_CLOCKS_EXT = 9'h100;
    localparam logic [8:0] BIT_CLOCKS_INT = 9'h14F;
    typedef enum logic [1:0] {
        MODE_USER = 2'b00,
        MODE_NORMAL_MON = 2'b01,
        MODE_FORCED_MON = 2'b11
    } bam_mode_t;
endpackage : bam_pkg

// ### hdl/bam_baud_if.sv
/*
 * bam_baud_if: carries the bit-period setting to the baud divider.
 * Assumes both ends share the system clock.
 */
`timescale 1ns/100ps
`default_nettype none
interface bam_baud_if;
    logic run;
    logic int_osc;
    logic tick;
    modport ctrl (output run, output int_osc, input tick);
    modport div (input run, input int_osc, output tick);
endinterface : bam_baud_if
`default_nettype wire

// ### hdl/bam_baud_div.sv
/*
 * bam_baud_div: one-cycle tick per monitor link bit period.
 * Assumes the bus clock drives the counter.
 */
`timescale 1ns/100ps
`default_nettype none
module bam_baud_div (
    input wire logic i_clk,
    input wire logic i_arst_n,
    bam_baud_if.div bif
);
    logic [8:0] cnt_q;
    wire [8:0] period = bif.int_osc ? bam_pkg::BIT_CLOCKS_INT : bam_pkg::BIT_CLOCKS_EXT;
    wire last = (cnt_q == period - 9'h001);
    assign bif.tick = bif.run & last;
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cnt_q <= 9'h000;
        end else if (!bif.run || last) begin
            cnt_q <= 9'h000;
        end else begin
            cnt_q <= cnt_q + 9'h001;
        end
    end
endmodule : bam_baud_div
`default_nettype wire

// ### hdl/bam_top.sv
/*
 * bam_top: breakpoint unit and monitor-entry decoder.
 * Assumes synchronous inputs, an 8-bit register port with read data one
 * cycle after the read strobe, and a CPU that honours the break request.
 */
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - in break, status flags clear only when clear-flag enable is set
// - timer counter halts while a break is in progress
// - watchdog-disable bit suppresses watchdog in any break, user or monitor mode; reset clears it
// - break enable at bit 7 gates 16-bit compare; write 0 or reset clears
// - match sets break active; writing 1 raises break; software writes 0
// - two address bytes hold compare address, reset to zero
// - wait-exit flag is 1 when a break ended wait mode
// - unit stays enabled in wait and stop, but no match break there
// - blank reset vector allows monitor entry without test voltage
// - programmed vector: normal monitor needs test voltage, link high, pins 1/0
// - forced monitor, interrupt pin high: external 9.8304 MHz clock
// - forced monitor, interrupt pin low: internal oscillator with trim at FFC0
// - no internal-oscillator entry when the reset vector is programmed
// - link bit period is 256 or 335 bus clocks
// - link pin is open-drain, wired-OR, board pull-up
// - programmed vector and no monitor condition: user mode, watchdog on
// - break forces swi opcode and selects user or monitor break vector
// - mode captured at rising edge of internal reset, then frozen
module bam_top (
    input wire logic I_CLK_SYS,
    input wire logic I_ARST_N,
    input wire logic [2:0] I_REG_ADDR,
    input wire logic [7:0] I_REG_WDATA,
    input wire logic I_REG_WR,
    input wire logic I_REG_RD,
    output logic [7:0] O_REG_RDATA,
    input wire logic [15:0] I_CPU_ADDR,
    input wire logic I_CPU_FETCH,
    input wire logic I_WAIT_MODE,
    input wire logic I_STOP_MODE,
    input wire logic I_BREAK_RETURN,
    input wire logic I_INT_RESET_N,
    input wire logic I_VECTOR_HIGH_ERASED,
    input wire logic I_VECTOR_LOW_ERASED,
    input wire logic I_TEST_HIGH_VOLTAGE,
    input wire logic I_IRQ_LEVEL,
    input wire logic I_MODE_PIN_ONE,
    input wire logic I_MODE_PIN_FOUR,
    input wire logic [7:0] I_OSCILLATOR_TRIM_VALUE,
    input wire logic I_SERIAL_LINK_PIN_IN,
    input wire logic I_LINK_TX,
    input wire logic I_FLAG_CLEAR_REQ,
    output logic O_SERIAL_LINK_PIN_OUT,
    output logic O_SERIAL_LINK_PIN_OE,
    output logic O_BREAKPOINT_SIGNAL,
    output logic O_FORCE_SWI,
    output logic [7:0] O_SWI_OPCODE,
    output logic [15:0] O_BREAK_VECTOR,
    output logic O_IN_BREAK,
    output logic O_TIMER_HALT,
    output logic O_WATCHDOG_ENABLE,
    output logic O_FLAG_CLEAR_ALLOW,
    output logic [1:0] O_MONITOR_MODE,
    output logic O_USE_INT_OSC,
    output logic [7:0] O_TRIM,
    output logic [15:0] O_TRIM_ADDRESS,
    output logic O_LINK_BIT_TICK
);
    ////////////////////////////////////////////////////////////////////////
    // registers
    logic break_enable_q;
    logic break_active_q;
    logic [7:0] break_address_high_q;
    logic [7:0] break_address_low_q;
    logic break_watchdog_disable_q;
    logic wait_exit_by_break_q;
    logic break_clear_flag_enable_q;
    logic in_break_q;
    logic match_q;
    logic [7:0] rdata_q;
    logic [1:0] mode_q;
    logic use_int_osc_q;
    logic reset_seen_q;
    logic prev_int_reset_q;
    logic [7:0] trim_q;

    ////////////////////////////////////////////////////////////////////////
    // address decode
    wire wr_scr = I_REG_WR && (I_REG_ADDR == bam_pkg::ADDR_BRK_STATUS_CONTROL);
    wire wr_bh = I_REG_WR && (I_REG_ADDR == bam_pkg::ADDR_BRK_ADDRESS_HIGH);
    wire wr_bl = I_REG_WR && (I_REG_ADDR == bam_pkg::ADDR_BRK_ADDRESS_LOW);
    wire wr_aux = I_REG_WR && (I_REG_ADDR == bam_pkg::ADDR_BRK_AUXILIARY);
    wire wr_bsr = I_REG_WR && (I_REG_ADDR == bam_pkg::ADDR_BRK_STATUS);
    wire wr_fcr = I_REG_WR && (I_REG_ADDR == bam_pkg::ADDR_BRK_FLAG_CONTROL);
    wire [15:0] break_address = {break_address_high_q, break_address_low_q};
    // address bus stalls in low-power modes, so a match there is ignored
    wire low_power = I_WAIT_MODE | I_STOP_MODE;
    wire addr_hit = break_enable_q && I_CPU_FETCH && !low_power
        && (I_CPU_ADDR == break_address);
    // only the first cycle of a match counts, a parked bus must not retrigger
    wire match_evt = addr_hit && !match_q;
    wire sw_break = wr_scr && I_REG_WDATA[bam_pkg::BIT_BREAK_ACTIVE];
    wire break_req = match_evt || sw_break;
    wire is_monitor = (mode_q != bam_pkg::MODE_USER);

    ////////////////////////////////////////////////////////////////////////
    // break state
    always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            break_enable_q <= 1'b0;
            break_active_q <= 1'b0;
            break_address_high_q <= bam_pkg::RESET_BYTE;
            break_address_low_q <= bam_pkg::RESET_BYTE;
            break_watchdog_disable_q <= 1'b0;
            break_clear_flag_enable_q <= 1'b0;
            match_q <= 1'b0;
            in_break_q <= 1'b0;
        end else begin
            match_q <= addr_hit;
            if (wr_scr) begin
                break_enable_q <= I_REG_WDATA[bam_pkg::BIT_BREAK_ENABLE];
            end
            // a match in the clearing cycle still wins
            if (break_req) begin
                break_active_q <= 1'b1;
            end else if (wr_scr) begin
                break_active_q <= I_REG_WDATA[bam_pkg::BIT_BREAK_ACTIVE];
            end
            if (wr_bh) begin
                break_address_high_q <= I_REG_WDATA;
            end
            if (wr_bl) begin
                break_address_low_q <= I_REG_WDATA;
            end
            if (wr_aux) begin
                break_watchdog_disable_q <= I_REG_WDATA[bam_pkg::BIT_WATCHDOG_DISABLE];
            end
            if (wr_fcr) begin
                break_clear_flag_enable_q <= I_REG_WDATA[bam_pkg::BIT_CLEAR_FLAG_ENABLE];
            end
            // break lasts until the return from the break routine
            if (break_req) begin
                in_break_q <= 1'b1;
            end else if (I_BREAK_RETURN) begin
                in_break_q <= 1'b0;
            end
        end
    end

    // wait-exit flag: set when a break arrives in wait mode, software clears
    always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            wait_exit_by_break_q <= 1'b0;
        end else if (sw_break && I_WAIT_MODE) begin
            wait_exit_by_break_q <= 1'b1;
        end else if (wr_bsr && !I_REG_WDATA[bam_pkg::BIT_WAIT_EXIT]) begin
            wait_exit_by_break_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read port
    wire [7:0] rd_scr = {break_enable_q, break_active_q, 6'h00};
    wire [7:0] rd_aux = {7'h00, break_watchdog_disable_q};
    wire [7:0] rd_bsr = {6'h00, wait_exit_by_break_q, 1'b0};
    wire [7:0] rd_fcr = {break_clear_flag_enable_q, 7'h00};
    wire [7:0] rd_mon = {4'h0, in_break_q, use_int_osc_q, mode_q};
    logic [7:0] rd_mux;
    assign rd_mux = (I_REG_ADDR == bam_pkg::ADDR_BRK_STATUS_CONTROL) ? rd_scr :
        (I_REG_ADDR == bam_pkg::ADDR_BRK_ADDRESS_HIGH) ? break_address_high_q :
        (I_REG_ADDR == bam_pkg::ADDR_BRK_ADDRESS_LOW) ? break_address_low_q :
        (I_REG_ADDR == bam_pkg::ADDR_BRK_AUXILIARY) ? rd_aux :
        (I_REG_ADDR == bam_pkg::ADDR_BRK_STATUS) ? rd_bsr :
        (I_REG_ADDR == bam_pkg::ADDR_BRK_FLAG_CONTROL) ? rd_fcr :
        (I_REG_ADDR == bam_pkg::ADDR_MON_STATUS) ? rd_mon : 8'h00;
    always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= I_REG_RD ? rd_mux : 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // monitor-mode entry
    wire vector_blank = I_VECTOR_HIGH_ERASED & I_VECTOR_LOW_ERASED;
    wire normal_cond = I_TEST_HIGH_VOLTAGE && I_SERIAL_LINK_PIN_IN
        && I_MODE_PIN_ONE && !I_MODE_PIN_FOUR;
    logic [1:0] mode_d;
    assign mode_d = normal_cond ? bam_pkg::MODE_NORMAL_MON :
        vector_blank ? bam_pkg::MODE_FORCED_MON :
        bam_pkg::MODE_USER;
    // internal oscillator only for blank vector with interrupt pin low
    wire int_osc_d = !normal_cond && vector_blank && !I_IRQ_LEVEL;
    wire reset_rise = I_INT_RESET_N && !prev_int_reset_q;
    always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            prev_int_reset_q <= 1'b0;
            reset_seen_q <= 1'b0;
            mode_q <= bam_pkg::MODE_USER;
            use_int_osc_q <= 1'b0;
            trim_q <= bam_pkg::RESET_BYTE;
        end else begin
            prev_int_reset_q <= I_INT_RESET_N;
            // latched once per power-on, pins are free afterwards
            if (reset_rise && !reset_seen_q) begin
                reset_seen_q <= 1'b1;
                mode_q <= mode_d;
                use_int_osc_q <= int_osc_d;
                trim_q <= (I_OSCILLATOR_TRIM_VALUE != bam_pkg::ERASED_BYTE)
                    ? I_OSCILLATOR_TRIM_VALUE : bam_pkg::RESET_BYTE;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // link timing
    bam_baud_if bif ();
    assign bif.run = is_monitor;
    assign bif.int_osc = use_int_osc_q;
    bam_baud_div u_baud (
        .i_clk(I_CLK_SYS),
        .i_arst_n(I_ARST_N),
        .bif(bif)
    );

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign O_REG_RDATA = rdata_q;
    assign O_BREAKPOINT_SIGNAL = break_req;
    assign O_FORCE_SWI = break_req;
    assign O_SWI_OPCODE = bam_pkg::SWI_OPCODE;
    assign O_BREAK_VECTOR = is_monitor ? bam_pkg::VEC_BREAK_MON
        : bam_pkg::VEC_BREAK_USER;
    assign O_IN_BREAK = in_break_q;
    assign O_TIMER_HALT = in_break_q;
    // watchdog off in any monitor mode, and in any break when asked
    assign O_WATCHDOG_ENABLE = !is_monitor
        && !(in_break_q && break_watchdog_disable_q);
    assign O_FLAG_CLEAR_ALLOW = I_FLAG_CLEAR_REQ
        && (!in_break_q || break_clear_flag_enable_q);
    assign O_MONITOR_MODE = mode_q;
    assign O_USE_INT_OSC = use_int_osc_q;
    assign O_TRIM = trim_q;
    assign O_TRIM_ADDRESS = bam_pkg::TRIM_ADDRESS;
    assign O_LINK_BIT_TICK = bif.tick;
    // open drain: only ever pull low, pull-up is on the board
    assign O_SERIAL_LINK_PIN_OUT = 1'b0;
    assign O_SERIAL_LINK_PIN_OE = is_monitor && !I_LINK_TX;
endmodule : bam_top
`default_nettype wire

// ### dv/bam_top_sva.sv
/* bam_top_sva: port-level assertions for bam_top.
   Assumes one clock domain and the asynchronous active-low reset. */
`timescale 1ns/100ps
`default_nettype none
module bam_top_sva (
    input wire logic I_CLK_SYS,
    input wire logic I_ARST_N,
    input wire logic I_REG_WR,
    input wire logic I_WAIT_MODE,
    input wire logic I_STOP_MODE,
    input wire logic I_BREAK_RETURN,
    input wire logic I_INT_RESET_N,
    input wire logic I_LINK_TX,
    input wire logic I_FLAG_CLEAR_REQ,
    input wire logic O_SERIAL_LINK_PIN_OE,
    input wire logic O_BREAKPOINT_SIGNAL,
    input wire logic O_FORCE_SWI,
    input wire logic [7:0] O_SWI_OPCODE,
    input wire logic [15:0] O_BREAK_VECTOR,
    input wire logic O_IN_BREAK,
    input wire logic O_TIMER_HALT,
    input wire logic O_WATCHDOG_ENABLE,
    input wire logic O_FLAG_CLEAR_ALLOW,
    input wire logic [1:0] O_MONITOR_MODE,
    input wire logic O_USE_INT_OSC,
    input wire logic O_LINK_BIT_TICK
);
    default clocking @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_ARST_N);
    wire mon_w = O_MONITOR_MODE != bam_pkg::MODE_USER;
    ////////////////////////////////////////
    swi_force_a: assert property (O_BREAKPOINT_SIGNAL |-> O_FORCE_SWI && O_SWI_OPCODE == bam_pkg::SWI_OPCODE)
        else $error("break without forced opcode");
    break_hold_a: assert property (O_BREAKPOINT_SIGNAL && !I_BREAK_RETURN |=> O_IN_BREAK)
        else $error("break request did not enter break");
    timer_halt_a: assert property (O_TIMER_HALT == O_IN_BREAK)
        else $error("timer halt differs from break state");
    low_power_a: assert property ((I_WAIT_MODE || I_STOP_MODE) && !I_REG_WR |-> !O_BREAKPOINT_SIGNAL)
        else $error("address break in low-power mode");
    vector_sel_a: assert property (O_BREAK_VECTOR == (mon_w ? 16'hFEFC : 16'hFFFC))
        else $error("wrong break vector");
    flag_gate_a: assert property (!I_FLAG_CLEAR_REQ || !O_IN_BREAK |-> O_FLAG_CLEAR_ALLOW == I_FLAG_CLEAR_REQ)
        else $error("flag clear gating wrong");
    mon_wdog_a: assert property (mon_w |-> !O_WATCHDOG_ENABLE)
        else $error("watchdog on in monitor mode");
    user_wdog_a: assert property (!mon_w && !O_IN_BREAK |-> O_WATCHDOG_ENABLE)
        else $error("watchdog off in user mode");
    link_oe_a: assert property (O_SERIAL_LINK_PIN_OE == (mon_w && !I_LINK_TX))
        else $error("link pin enable wrong");
    mode_hold_a: assert property (I_INT_RESET_N [*4] |-> $stable(O_MONITOR_MODE))
        else $error("mode changed outside reset edge");
    tick_ext_a: assert property (O_LINK_BIT_TICK && !O_USE_INT_OSC |-> ##256 O_LINK_BIT_TICK)
        else $error("external bit period wrong");
    tick_int_a: assert property (O_LINK_BIT_TICK && O_USE_INT_OSC |-> ##[335:335] O_LINK_BIT_TICK)
        else $error("internal bit period wrong");
endmodule : bam_top_sva
bind bam_top bam_top_sva u_sva (
    .I_CLK_SYS(I_CLK_SYS),
    .I_ARST_N(I_ARST_N),
    .I_REG_WR(I_REG_WR),
    .I_WAIT_MODE(I_WAIT_MODE),
    .I_STOP_MODE(I_STOP_MODE),
    .I_BREAK_RETURN(I_BREAK_RETURN),
    .I_INT_RESET_N(I_INT_RESET_N),
    .I_LINK_TX(I_LINK_TX),
    .I_FLAG_CLEAR_REQ(I_FLAG_CLEAR_REQ),
    .O_SERIAL_LINK_PIN_OE(O_SERIAL_LINK_PIN_OE),
    .O_BREAKPOINT_SIGNAL(O_BREAKPOINT_SIGNAL),
    .O_FORCE_SWI(O_FORCE_SWI),
    .O_SWI_OPCODE(O_SWI_OPCODE),
    .O_BREAK_VECTOR(O_BREAK_VECTOR),
    .O_IN_BREAK(O_IN_BREAK),
    .O_TIMER_HALT(O_TIMER_HALT),
    .O_WATCHDOG_ENABLE(O_WATCHDOG_ENABLE),
    .O_FLAG_CLEAR_ALLOW(O_FLAG_CLEAR_ALLOW),
    .O_MONITOR_MODE(O_MONITOR_MODE),
    .O_USE_INT_OSC(O_USE_INT_OSC),
    .O_LINK_BIT_TICK(O_LINK_BIT_TICK)
);
`default_nettype wire

// ### dv/bam_host.sv
/* bam_host: host end of the single-wire monitor link.
   Assumes an open-drain device and a board pull-up on the pin. */
`timescale 1ns/100ps
`default_nettype none
module bam_host (
    input wire logic i_dev_oe,
    input wire logic i_host_low,
    output logic o_pin
);
    // wired-OR: either side pulls low, otherwise the pull-up wins
    assign o_pin = !(i_dev_oe || i_host_low);
endmodule : bam_host
`default_nettype wire

// ### dv/break_and_monitor_entry_bench.sv
/* break_and_monitor_entry_bench: self-checking bench for bam_top.
   Assumes bam_host closes the link pin and bam_top_sva is bound. */
`timescale 1ns/100ps
`default_nettype none
module break_and_monitor_entry_bench;
    logic clk, arst_n, wr, rd, fetch, wait_m, stop_m, brk_ret, int_rst_n, ve, tst, irq;
    logic pin1, pin4, link_tx, clr_req, host_low, pin_out, pin_oe, breakpoint_signal, software_interrupt_op, in_brk;
    logic thalt, wdog, clr_ok, int_osc, tick, link_pin;
    logic [1:0] mode;
    logic [2:0] addr;
    logic [7:0] wdata, rdata, opc, trim_o, trim_i;
    logic [15:0] cpu_addr, vec, trim_a;
    logic [18:0] rows [6];
    int err_total, total_checks;
    bam_top DUT (.I_CLK_SYS(clk), .I_ARST_N(arst_n), .I_REG_ADDR(addr), .I_REG_WDATA(wdata),
        .I_REG_WR(wr), .I_REG_RD(rd), .O_REG_RDATA(rdata), .I_CPU_ADDR(cpu_addr),
        .I_CPU_FETCH(fetch), .I_WAIT_MODE(wait_m), .I_STOP_MODE(stop_m),
        .I_BREAK_RETURN(brk_ret), .I_INT_RESET_N(int_rst_n), .I_VECTOR_HIGH_ERASED(ve),
        .I_VECTOR_LOW_ERASED(ve), .I_TEST_HIGH_VOLTAGE(tst), .I_IRQ_LEVEL(irq),
        .I_MODE_PIN_ONE(pin1), .I_MODE_PIN_FOUR(pin4), .I_OSCILLATOR_TRIM_VALUE(trim_i),
        .I_SERIAL_LINK_PIN_IN(link_pin), .I_LINK_TX(link_tx), .I_FLAG_CLEAR_REQ(clr_req),
        .O_SERIAL_LINK_PIN_OUT(pin_out), .O_SERIAL_LINK_PIN_OE(pin_oe),
        .O_BREAKPOINT_SIGNAL(breakpoint_signal), .O_FORCE_SWI(software_interrupt_op), .O_SWI_OPCODE(opc),
        .O_BREAK_VECTOR(vec), .O_IN_BREAK(in_brk), .O_TIMER_HALT(thalt),
        .O_WATCHDOG_ENABLE(wdog), .O_FLAG_CLEAR_ALLOW(clr_ok), .O_MONITOR_MODE(mode),
        .O_USE_INT_OSC(int_osc), .O_TRIM(trim_o), .O_TRIM_ADDRESS(trim_a),
        .O_LINK_BIT_TICK(tick));
    bam_host u_host (.i_dev_oe(pin_oe), .i_host_low(host_low), .o_pin(link_pin));
    ////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask : wr_reg
    task automatic rd_reg(input logic [2:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(16'(rdata), 16'(e));
    endtask : rd_reg
    task automatic do_reset;
        @(posedge clk);
        arst_n <= 1'b0;
        int_rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        int_rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
    endtask : do_reset
    task automatic ret_pulse;
        @(posedge clk);
        brk_ret <= 1'b1;
        @(posedge clk);
        brk_ret <= 1'b0;
        #1;
    endtask : ret_pulse
    task automatic mode_case(input logic e, t, q, p1, p4, hl, input logic [1:0] em, input logic eo);
        int k, first, n;
        first = -1;
        n = 0;
        @(posedge clk);
        ve <= e;
        tst <= t;
        irq <= q;
        pin1 <= p1;
        pin4 <= p4;
        host_low <= hl;
        do_reset;
        chk(16'(mode), 16'(em));
        chk(16'(int_osc), 16'(eo));
        chk(16'(wdog), 16'(em == 2'b00));
        chk(vec, (em == 2'b00) ? 16'hFFFC : 16'hFEFC);
        @(posedge clk);
        pin1 <= ~p1;
        pin4 <= ~p4;
        host_low <= 1'b0;
        link_tx <= 1'b0;
        #1 chk(16'(link_pin), 16'(em == 2'b00));
        chk(16'(pin_out), 16'h0);
        @(posedge clk);
        link_tx <= 1'b1;
        repeat (4) @(posedge clk);
        #1 chk(16'(mode), 16'(em));
        if (eo) chk(trim_o, (trim_i == 8'hFF) ? 16'h0000 : 16'(trim_i));
        if (eo) chk(trim_a, 16'hFFC0);
        // two ticks give one full period; user mode must never tick
        for (k = 0; k < 700 && n == 0; k++) begin
            @(posedge clk);
            #1;
            if (tick === 1'b1) begin
                if (first < 0) first = k;
                else n = k - first;
            end
        end
        if (em != 2'b00) chk(16'(n), eo ? 16'd335 : 16'd256);
        if (em == 2'b00) chk(16'(first + 1), 16'h0000);
    endtask : mode_case
    task automatic report_and_stop;
        if (err_total == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : report_and_stop
    ////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        report_and_stop;
    end
    initial begin
        {arst_n, wr, rd, fetch, wait_m, stop_m, brk_ret, int_rst_n, ve, tst} = '0;
        {irq, pin1, pin4, clr_req, host_low} = 5'h10;
        link_tx = 1'b1;
        trim_i = 8'h3C;
        addr = 3'h0;
        wdata = 8'h00;
        cpu_addr = 16'h0000;
        rows = '{19'h11212, 19'h23434, 19'h30101, 19'h58080, 19'h6FF00, 19'h7FF00};
        do_reset;
        chk(16'(wdog), 16'h1);
        for (int i = 0; i < 8; i++) rd_reg(3'(i), 8'h00);
        for (int i = 0; i < 6; i++) begin
            wr_reg(rows[i][18:16], rows[i][15:8]);
            rd_reg(rows[i][18:16], rows[i][7:0]);
        end
        wr_reg(3'h0, 8'h80);
        @(posedge clk);
        cpu_addr <= 16'h1233;
        fetch <= 1'b1;
        #1 chk(16'(breakpoint_signal), 16'h0);
        @(posedge clk);
        cpu_addr <= 16'h1234;
        #1 chk(16'(breakpoint_signal), 16'h1);
        chk(16'(software_interrupt_op), 16'h1);
        chk(16'(opc), 16'(bam_pkg::SWI_OPCODE));
        chk(vec, 16'hFFFC);
        @(posedge clk);
        fetch <= 1'b0;
        clr_req <= 1'b1;
        #1 chk(16'(thalt), 16'h1);
        chk(16'(wdog), 16'h0);
        chk(16'(clr_ok), 16'h1);
        rd_reg(3'h0, 8'hC0);
        wr_reg(3'h5, 8'h00);
        chk(16'(clr_ok), 16'h0);
        wr_reg(3'h0, 8'h80);
        rd_reg(3'h0, 8'h80);
        ret_pulse;
        chk(16'(in_brk), 16'h0);
        chk(16'(wdog), 16'h1);
        chk(16'(clr_ok), 16'h1);
        @(posedge clk);
        wait_m <= 1'b1;
        stop_m <= 1'b1;
        fetch <= 1'b1;
        #1 chk(16'(breakpoint_signal), 16'h0);
        wr_reg(3'h0, 8'hC0);
        chk(16'(in_brk), 16'h1);
        rd_reg(3'h4, 8'h02);
        wr_reg(3'h4, 8'h00);
        rd_reg(3'h4, 8'h00);
        ret_pulse;
        @(posedge clk);
        {wait_m, stop_m, fetch, clr_req} <= 4'h0;
        mode_case(1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 2'b01, 1'b0);
        mode_case(1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 2'b00, 1'b0);
        mode_case(1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 2'b00, 1'b0);
        mode_case(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 2'b00, 1'b0);
        mode_case(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 2'b11, 1'b0);
        // irq stays low for the whole internal-clock session
        mode_case(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 2'b11, 1'b1);
        // erased trim byte must not be applied
        @(posedge clk);
        trim_i <= 8'hFF;
        mode_case(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 2'b11, 1'b1);
        report_and_stop;
    end
endmodule : break_and_monitor_entry_bench
`default_nettype wire
